// ===== core/prr_pkg.sv
// shared constants, types and register map of the pin route unit
package prr_pkg;

    // port geometry and selector width
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 5;
    localparam int SEL_W = 6;

    // register byte offsets on the bus
    localparam logic [11:0] LOCK_OFS = 12'h000;
    localparam logic [11:0] LEVEL_BASE = 12'h020;
    localparam logic [11:0] DIR_BASE = 12'h040;
    localparam logic [11:0] LATCH_BASE = 12'h060;
    localparam logic [11:0] IN_SEL_BASE = 12'h100;
    localparam logic [11:0] OUT_SEL_BASE = 12'h200;

    // lock register fields and unlock keys
    localparam int LOCK_BIT = 0;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

    // values after reset
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [5:0] OUT_SEL_RESET = 6'h00;
    localparam logic [7:0][5:0] IN_SEL_RESET = {6'h0C, 6'h12, 6'h10,
        6'h10, 6'h0D, 6'h10, 6'h04, 6'h08};

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // unlock sequence progress
    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_KEY1 = 2'b01,
        SEQ_ARMED = 2'b10
    } prr_seq_t;

    // a held bus write: address, data and byte strobes
    typedef struct packed
    {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } prr_wreq_t;

endpackage : prr_pkg

// ===== core/prr_sel_mux.sv
// one-of-n selector returning zero for codes beyond the last input
`timescale 1ns/1ns
module prr_sel_mux #(
    parameter int N = 40,
    parameter int SW = 6
) (
    input wire logic [N-1:0] src,
    input wire logic [SW-1:0] sel,
    output logic pick
);
    // codes past the last input pick a constant low
    always_comb
    begin
        pick = 1'b0;
        if (int'(sel) < N)
        begin
            pick = src[sel];
        end
    end
endmodule : prr_sel_mux

// ===== core/prr_router.sv
// pin route unit: input/output routing, lock logic and axi4-lite registers
`timescale 1ns/1ns
module prr_router #(
    parameter int NUM_IN = 8,
    parameter int NUM_SRC = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic one_shot_lock_fuse,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [prr_pkg::NUM_PORTS*prr_pkg::PORT_W-1:0] pin_in,
    output logic [prr_pkg::NUM_PORTS*prr_pkg::PORT_W-1:0] pin_out,
    output logic [prr_pkg::NUM_PORTS*prr_pkg::PORT_W-1:0] pin_oe_n,
    output logic [NUM_IN-1:0] periph_in,
    input wire logic [NUM_SRC-1:0] periph_out,
    input wire logic [NUM_SRC-1:0] periph_drive_ovr,
    input wire logic [NUM_SRC-1:0] periph_drive_en
);
    import prr_pkg::*;

    localparam int NUM_PINS = NUM_PORTS * PORT_W;

    // register file and bus state
    logic [NUM_IN-1:0][SEL_W-1:0] in_sel, next_in_sel;
    logic [NUM_PINS-1:0][SEL_W-1:0] out_sel, next_out_sel;
    logic [NUM_PORTS-1:0][PORT_W-1:0] dir, next_dir;
    logic [NUM_PORTS-1:0][PORT_W-1:0] latch, next_latch;
    logic lock_flag, next_lock_flag;
    prr_seq_t seq, next_seq;
    prr_wreq_t wreq, next_wreq;
    logic aw_full, next_aw_full;
    logic w_full, next_w_full;
    logic [1:0] bresp, next_bresp;
    logic bvalid, next_bvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic rvalid, next_rvalid;
    logic wr_do, rd_do;

    // index of a register within a block, or -1 when outside it
    function automatic int reg_index(input logic [11:0] addr,
                                     input logic [11:0] base,
                                     input int count);
        int idx;
        idx = -1;
        if (addr >= base && addr[1:0] == 2'b00 &&
            int'((addr - base) >> 2) < count)
        begin
            idx = int'((addr - base) >> 2);
        end
        return idx;
    endfunction : reg_index

    // handshake outputs straight from the hold state
    assign s_axi_awready = !aw_full;
    assign s_axi_wready = !w_full;
    assign s_axi_arready = !rvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_bvalid = bvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign s_axi_rvalid = rvalid;
    assign wr_do = aw_full && w_full && !bvalid;
    assign rd_do = s_axi_arvalid && !rvalid;

    // next state of bus slave, registers and lock sequence
    always_comb
    begin
        int ii;
        int io;
        int ip;
        logic [7:0] wbyte;
        ii = -1;
        io = -1;
        ip = -1;
        wbyte = wreq.data[7:0];
        next_in_sel = in_sel;
        next_out_sel = out_sel;
        next_dir = dir;
        next_latch = latch;
        next_lock_flag = lock_flag;
        next_seq = seq;
        next_wreq = wreq;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_bresp = bresp;
        next_bvalid = bvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_rvalid = rvalid;
        // address and data are taken independently, in either order
        if (s_axi_awvalid && !aw_full)
        begin
            next_wreq.addr = s_axi_awaddr;
            next_aw_full = 1'b1;
        end
        if (s_axi_wvalid && !w_full)
        begin
            next_wreq.data = s_axi_wdata;
            next_wreq.strb = s_axi_wstrb;
            next_w_full = 1'b1;
        end
        if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        // commit a write once both halves are held
        if (wr_do)
        begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            next_seq = SEQ_IDLE;
            if (wreq.addr == LOCK_OFS)
            begin
                if (wreq.strb[0])
                begin
                    if (seq == SEQ_ARMED)
                    begin
                        // fuse makes a set flag permanent until reset
                        if (!(one_shot_lock_fuse && lock_flag))
                        begin
                            next_lock_flag = wbyte[LOCK_BIT];
                        end
                    end
                    else if (wbyte == UNLOCK_KEY1)
                    begin
                        next_seq = SEQ_KEY1;
                    end
                    if (seq == SEQ_KEY1 && wbyte == UNLOCK_KEY2)
                    begin
                        next_seq = SEQ_ARMED;
                    end
                end
            end
            else if (reg_index(wreq.addr, IN_SEL_BASE, NUM_IN) >= 0)
            begin
                ii = reg_index(wreq.addr, IN_SEL_BASE, NUM_IN);
                if (wreq.strb[0] && !lock_flag)
                begin
                    next_in_sel[ii] = wbyte[SEL_W-1:0];
                end
            end
            else if (reg_index(wreq.addr, OUT_SEL_BASE, NUM_PINS) >= 0)
            begin
                io = reg_index(wreq.addr, OUT_SEL_BASE, NUM_PINS);
                if (wreq.strb[0] && !lock_flag)
                begin
                    next_out_sel[io] = wbyte[SEL_W-1:0];
                end
            end
            else if (reg_index(wreq.addr, DIR_BASE, NUM_PORTS) >= 0)
            begin
                ip = reg_index(wreq.addr, DIR_BASE, NUM_PORTS);
                if (wreq.strb[0])
                begin
                    next_dir[ip] = wbyte;
                end
            end
            else if (reg_index(wreq.addr, LATCH_BASE, NUM_PORTS) >= 0)
            begin
                ip = reg_index(wreq.addr, LATCH_BASE, NUM_PORTS);
                if (wreq.strb[0])
                begin
                    next_latch[ip] = wbyte;
                end
            end
            else if (reg_index(wreq.addr, LEVEL_BASE, NUM_PORTS) < 0)
            begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
        // a read answers one cycle after it is taken
        if (rd_do)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            next_seq = SEQ_IDLE;
            if (s_axi_araddr == LOCK_OFS)
            begin
                next_rdata[LOCK_BIT] = lock_flag;
            end
            else if (reg_index(s_axi_araddr, LEVEL_BASE, NUM_PORTS) >= 0)
            begin
                ip = reg_index(s_axi_araddr, LEVEL_BASE, NUM_PORTS);
                next_rdata[7:0] = pin_in[ip*PORT_W +: PORT_W];
            end
            else if (reg_index(s_axi_araddr, DIR_BASE, NUM_PORTS) >= 0)
            begin
                ip = reg_index(s_axi_araddr, DIR_BASE, NUM_PORTS);
                next_rdata[7:0] = dir[ip];
            end
            else if (reg_index(s_axi_araddr, LATCH_BASE, NUM_PORTS) >= 0)
            begin
                ip = reg_index(s_axi_araddr, LATCH_BASE, NUM_PORTS);
                next_rdata[7:0] = latch[ip];
            end
            else if (reg_index(s_axi_araddr, IN_SEL_BASE, NUM_IN) >= 0)
            begin
                ii = reg_index(s_axi_araddr, IN_SEL_BASE, NUM_IN);
                next_rdata[SEL_W-1:0] = in_sel[ii];
            end
            else if (reg_index(s_axi_araddr, OUT_SEL_BASE, NUM_PINS) >= 0)
            begin
                io = reg_index(s_axi_araddr, OUT_SEL_BASE, NUM_PINS);
                next_rdata[SEL_W-1:0] = out_sel[io];
            end
            else
            begin
                next_rresp = RESP_SLVERR;
            end
        end
    end

    // selections follow power-on reset only; no sleep input touches them
    always_ff @(posedge clk)
    begin
        if (!por_n)
        begin
            in_sel <= IN_SEL_RESET;
            for (int p = 0; p < NUM_PINS; p++)
            begin
                out_sel[p] <= OUT_SEL_RESET;
            end
        end
        else
        begin
            in_sel <= next_in_sel;
            out_sel <= next_out_sel;
        end
    end

    // remaining state clears on any reset
    always_ff @(posedge clk)
    begin
        if (!rst_n || !por_n)
        begin
            for (int q = 0; q < NUM_PORTS; q++)
            begin
                dir[q] <= DIR_RESET;
                latch[q] <= LATCH_RESET;
            end
            lock_flag <= 1'b0;
            seq <= SEQ_IDLE;
            wreq <= '0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bresp <= RESP_OKAY;
            bvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            rvalid <= 1'b0;
        end
        else
        begin
            dir <= next_dir;
            latch <= next_latch;
            lock_flag <= next_lock_flag;
            seq <= next_seq;
            wreq <= next_wreq;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            bresp <= next_bresp;
            bvalid <= next_bvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            rvalid <= next_rvalid;
        end
    end

    // routing paths: pins to peripherals, sources to pins
    logic [NUM_IN-1:0] next_periph_in;
    logic [NUM_PINS-1:0] next_pin_out, next_pin_oe_n, ovr_hit, ovr_en;

    // digital pins only; code equals port*8+bit, codes past port e give 0
    generate
        for (genvar gi = 0; gi < NUM_IN; gi++)
        begin : g_in
            prr_sel_mux #(.N(NUM_PINS), .SW(SEL_W)) u_in_mux (
                .src(pin_in),
                .sel(in_sel[gi]),
                .pick(next_periph_in[gi])
            );
        end
        for (genvar gp = 0; gp < NUM_PINS; gp++)
        begin : g_pin
            // code 0 is the port latch, other codes the peripheral outputs
            prr_sel_mux #(.N(NUM_SRC), .SW(SEL_W)) u_data_mux (
                .src({periph_out[NUM_SRC-1:1], latch[gp/PORT_W][gp%PORT_W]}),
                .sel(out_sel[gp]),
                .pick(next_pin_out[gp])
            );
            prr_sel_mux #(.N(NUM_SRC), .SW(SEL_W)) u_ovr_mux (
                .src({periph_drive_ovr[NUM_SRC-1:1], 1'b0}),
                .sel(out_sel[gp]),
                .pick(ovr_hit[gp])
            );
            prr_sel_mux #(.N(NUM_SRC), .SW(SEL_W)) u_en_mux (
                .src({periph_drive_en[NUM_SRC-1:1], 1'b0}),
                .sel(out_sel[gp]),
                .pick(ovr_en[gp])
            );
            // direction bit rules unless the routed peripheral overrides
            assign next_pin_oe_n[gp] = ovr_hit[gp] ? !ovr_en[gp]
                : dir[gp/PORT_W][gp%PORT_W];
        end
    endgenerate

    // registered pin and peripheral data
    always_ff @(posedge clk)
    begin
        if (!rst_n || !por_n)
        begin
            periph_in <= '0;
            pin_out <= '0;
            pin_oe_n <= '1;
        end
        else
        begin
            periph_in <= next_periph_in;
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
        end
    end

    // helpers seen only by the checks below
    logic exp_in0, dir00;
    logic [7:0] lvl0;
    assign exp_in0 = (in_sel[0] < 6'd40) ? pin_in[in_sel[0]] : 1'b0;
    assign dir00 = dir[0][0];
    assign lvl0 = pin_in[7:0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !por_n);

    sequence s_level_req;
        rd_do && s_axi_araddr == LEVEL_BASE;
    endsequence

    sequence s_level_ans;
        s_axi_rvalid && s_axi_rdata[7:0] == $past(lvl0);
    endsequence

    chk_sel_frozen: assert property (
        lock_flag |=> $stable(in_sel) && $stable(out_sel))
        else $error("selector changed while locked");
    chk_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_in_route: assert property (
        rst_n && por_n |=> periph_in[0] == $past(exp_in0))
        else $error("peripheral input not from selected pin");
    chk_port_level: assert property (
        s_level_req |=> s_level_ans)
        else $error("port read not pin level");
    chk_dir_drive: assert property (
        out_sel[0] == 6'h00 |=> pin_oe_n[0] == $past(dir00))
        else $error("pin enable not from direction bit");
    chk_drive_ovr: assert property (
        ovr_hit[0] |=> pin_oe_n[0] == !$past(ovr_en[0]))
        else $error("peripheral override not applied");
    chk_unlock_seq: assert property (
        $changed(lock_flag) |-> $past(seq) == SEQ_ARMED)
        else $error("lock flag changed without unlock");
    chk_one_shot: assert property (
        one_shot_lock_fuse && lock_flag ##1 one_shot_lock_fuse |-> lock_flag)
        else $error("one-shot lock released");
    chk_por_default: assert property (
        $rose(por_n) && rst_n |-> in_sel[0] == IN_SEL_RESET[0])
        else $error("input selection not default after power-on");

endmodule : prr_router

// ===== bench/prr_pin_model.sv
// pad model: driven pins echo the unit, released pins follow the outside
`timescale 1ns/1ns
module prr_pin_model (
    input wire logic [prr_pkg::NUM_PORTS*prr_pkg::PORT_W-1:0] pin_out,
    input wire logic [prr_pkg::NUM_PORTS*prr_pkg::PORT_W-1:0] pin_oe_n,
    input wire logic [prr_pkg::NUM_PORTS*prr_pkg::PORT_W-1:0] ext_level,
    output logic [prr_pkg::NUM_PORTS*prr_pkg::PORT_W-1:0] pin_in
);
    import prr_pkg::*;
    // digital input buffers always enabled, so the level reaches the unit
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : prr_pin_model

// ===== bench/prr_router_tb.sv
// self-checking bench of the pin route unit
`timescale 1ns/1ns
module prr_router_tb;
    import prr_pkg::*;
    localparam int NP = NUM_PORTS*PORT_W;
    logic clk = 0;
    logic rst_n = 0;
    logic por_n = 0;
    logic fuse = 0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rdat;
    logic [NP-1:0] pin_in, pin_out, pin_oe_n;
    logic [NP-1:0] ext = '0;
    logic [7:0] periph_in;
    logic [63:0] pout = '0, ovr = '0, den = '0;
    logic [5:0] c;
    int seed = 32'h1a12_9a8f;
    int k, p, n_mismatch = 0, cmp_count = 0;
    logic [1:0] wr_exp = RESP_OKAY;

    // clock at 100 MHz
    always #5 clk = ~clk;

    prr_router i_prr_router (.clk(clk), .rst_n(rst_n), .por_n(por_n),
        .one_shot_lock_fuse(fuse), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .periph_in(periph_in), .periph_out(pout),
        .periph_drive_ovr(ovr), .periph_drive_en(den));

    prr_pin_model i_prr_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext), .pin_in(pin_in));

    // verdict and end of run
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // compare seen against expected
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    // a bus answer that never came
    task automatic hang;
        chk("bus answer", 0, 1);
        summarize();
    endtask : hang

    // one write, both halves offered together
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20 && !(bvalid && bready); n++)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                resp = bresp;
        end
        bready <= 1'b0;
        if (n == 20)
            hang();
        chk("bresp", resp, wr_exp);
    endtask : wr

    // one read, data and response kept in rdat and resp
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        rdat = rdata;
        resp = rresp;
        if (n == 20)
            hang();
    endtask : rd

    // unlock keys then the new flag value
    task automatic seq(input logic [7:0] v);
        wr(LOCK_OFS, UNLOCK_KEY1);
        wr(LOCK_OFS, UNLOCK_KEY2);
        wr(LOCK_OFS, v);
    endtask : seq

    // level a peripheral input should see for a code
    function automatic logic exp_in(input logic [5:0] s,
                                    input logic [NP-1:0] lv);
        if (s[5:3] > 3'd4)
            return 1'b0;
        return lv[s[5:3]*8 + s[2:0]];
    endfunction : exp_in

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rd(LOCK_OFS);
        chk("lock", rdat, 0);
        rd(DIR_BASE);
        chk("dir", rdat, DIR_RESET);
        for (k = 0; k < 8; k++)
        begin
            rd(IN_SEL_BASE + 12'(4*k));
            chk("in_sel", rdat, IN_SEL_RESET[k]);
        end
        rd(12'h0FC);
        chk("rresp", resp, RESP_SLVERR);
        chk("rdata", rdat, 0);
        // unmapped write answers with an error response
        wr_exp = RESP_SLVERR;
        wr(12'h0FC, 8'h5A);
        wr_exp = RESP_OKAY;
        $display("test reset done");
        for (k = 0; k < 16; k++)
        begin
            c = (k == 0) ? 6'h3A : {3'($unsigned($random(seed)) % 5),
                3'($random(seed))};
            wr(IN_SEL_BASE + 12'(4*(k%8)), {2'b11, c});
            rd(IN_SEL_BASE + 12'(4*(k%8)));
            chk("in_sel", rdat, c);
            ext <= NP'({$random(seed), $random(seed)});
            repeat (3) @(posedge clk);
            chk("periph_in", periph_in[k%8], exp_in(c, ext));
            chk("pin_oe_n", 32'(&pin_oe_n), 1);
        end
        wr(IN_SEL_BASE, 8'h12);
        wr(IN_SEL_BASE + 12'h004, 8'h12);
        repeat (3) @(posedge clk);
        chk("periph_in", periph_in[1:0], {2{ext[18]}});
        for (k = 0; k < NUM_PORTS; k++)
        begin
            rd(LEVEL_BASE + 12'(4*k));
            chk("level", rdat, ext[k*8+:8]);
        end
        $display("test input routing done");
        for (k = 0; k < 8; k++)
        begin
            p = (k == 0) ? 0 : $unsigned($random(seed)) % NP;
            c = 6'(1 + $unsigned($random(seed)) % 63);
            wr(OUT_SEL_BASE + 12'(4*p), {2'b11, c});
            rd(OUT_SEL_BASE + 12'(4*p));
            chk("out_sel", rdat, c);
            wr(DIR_BASE + 12'(4*(p/8)), ~(8'h01 << (p%8)));
            pout <= {$random(seed), $random(seed)};
            repeat (3) @(posedge clk);
            chk("pin_out", pin_out[p], pout[c]);
            chk("pin_oe_n", pin_oe_n[p], 0);
            wr(DIR_BASE + 12'(4*(p/8)), 8'hFF);
            wr(IN_SEL_BASE, {2'b00, 3'(p/8), 3'(p%8)});
            ovr[c] <= 1'b1;
            den[c] <= 1'b1;
            repeat (3) @(posedge clk);
            chk("pin_oe_n", pin_oe_n[p], 0);
            chk("periph_in", periph_in[0], pout[c]);
            den[c] <= 1'b0;
            repeat (3) @(posedge clk);
            chk("pin_oe_n", pin_oe_n[p], 1);
            ovr[c] <= 1'b0;
        end
        $display("test output routing done");
        wr(IN_SEL_BASE + 12'h008, 8'h21);
        seq(8'h01);
        rd(LOCK_OFS);
        chk("lock", rdat, 1);
        wr(IN_SEL_BASE + 12'h008, 8'h05);
        wr(OUT_SEL_BASE + 12'(4*p), 8'h00);
        rd(IN_SEL_BASE + 12'h008);
        chk("in_sel", rdat, 8'h21);
        rd(OUT_SEL_BASE + 12'(4*p));
        chk("out_sel", rdat, c);
        wr(LOCK_OFS, 8'h00);
        wr(LOCK_OFS, UNLOCK_KEY1);
        rd(LOCK_OFS);
        wr(LOCK_OFS, UNLOCK_KEY2);
        wr(LOCK_OFS, 8'h00);
        rd(LOCK_OFS);
        chk("lock", rdat, 1);
        seq(8'h00);
        rd(LOCK_OFS);
        chk("lock", rdat, 0);
        $display("test lock done");
        fuse <= 1'b1;
        seq(8'h00);
        seq(8'h01);
        seq(8'h00);
        rd(LOCK_OFS);
        chk("lock", rdat, 1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(LOCK_OFS);
        chk("lock", rdat, 0);
        rd(IN_SEL_BASE + 12'h008);
        chk("in_sel", rdat, 8'h21);
        por_n <= 1'b0;
        repeat (2) @(posedge clk);
        por_n <= 1'b1;
        rd(IN_SEL_BASE + 12'h008);
        chk("in_sel", rdat, IN_SEL_RESET[2]);
        rd(OUT_SEL_BASE + 12'(4*p));
        chk("out_sel", rdat, OUT_SEL_RESET);
        // code 0 routes the port latch once the direction bits drive
        wr(LATCH_BASE + 12'h004, 8'hA5);
        rd(LATCH_BASE + 12'h004);
        chk("latch", rdat, 8'hA5);
        wr(DIR_BASE + 12'h004, 8'h00);
        repeat (3) @(posedge clk);
        chk("pin_out", pin_out[15:8], 8'hA5);
        chk("pin_oe_n", pin_oe_n[15:8], 0);
        $display("test fuse and resets done");
        summarize();
    end
endmodule : prr_router_tb
